// ### rtl/vsf_bank.sv
/*
 Command register bank for feedback scale, output floor and switching frequency settings.
 Assumes a bus front end that presents whole-word commands on this clock, same-clock setpoint
 and slew inputs, and asynchronous pins for conversion enable and supply undervoltage.
*/
// Operation
// - Feedback scale word: exponent bits 15:11 reset 11001b, mantissa low 11 bits.
// - Scale and frequency reach hardware at once only while conversion is off.
// - Any in-range scale value is stored and read back unchanged.
// - Divider factor picks 0.125, 0.25, 0.5 or 1.0 from decoded scale.
// - Out-of-range scale or floor writes are invalid, flagged, and alert the host.
// - Reference scaling uses the stored scale itself, even unsupported values.
// - Floor at code 2Bh is an unsigned absolute 16-bit word.
// - Commanded target never goes below the stored floor.
// - Target below floor during conversion warns and slews output to the floor.
// - Warning sets catch-all, status-word output bit, limit bit, and alerts.
// - A newly written limit putting target outside the window warns the same.
// - Floor uses the same valid range as the ceiling limit.
// - Frequency at code 33h is a linear word in kHz.
// - Frequency exponent at reset is generated from the stored frequency.
module vsf_bank
    import vsf_pkg::*;
#(
    parameter logic [15:0] LIMIT_MIN = 16'h0000,
    parameter logic [15:0] LIMIT_MAX = 16'hFFFF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire vsf_cmd_t cmd,
    output logic rsp_valid_q,
    output logic rsp_ack_q,
    output logic [15:0] rsp_data_q,
    input wire logic clear_status,
    input wire logic conv_enable_pin,
    input wire logic supply_undervoltage_lockout_pin,
    input wire logic restore_pulse,
    input wire logic [15:0] nvm_feedback_scale,
    input wire logic [15:0] nvm_output_floor_limit,
    input wire logic [10:0] nvm_switching_khz,
    input wire logic [15:0] request_target,
    input wire logic [15:0] output_slew_setting,
    output logic [15:0] hw_feedback_scale_q,
    output vsf_div_t divider_sel_q,
    output logic [10:0] effective_khz_q,
    output logic [15:0] vout_target_q,
    output vsf_status_t status_q,
    output logic alert_q
);
    // ------------------------------------------------------------
    // Synchronisers and power-on load
    // ------------------------------------------------------------
    logic [1:0] conv_sync_q;
    logic [1:0] supply_undervoltage_lockout_sync_q;
    logic supply_undervoltage_lockout_prev_q;
    logic load_q;
    wire conv_on = conv_sync_q[1];
    // Leaving lockout counts as a supply cycle
    wire supply_undervoltage_lockout_release = supply_undervoltage_lockout_prev_q & ~supply_undervoltage_lockout_sync_q[1];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conv_sync_q <= 2'b00;
            supply_undervoltage_lockout_sync_q <= 2'b00;
            supply_undervoltage_lockout_prev_q <= 1'b0;
            load_q <= 1'b1;
        end else begin
            conv_sync_q <= {conv_sync_q[0], conv_enable_pin};
            supply_undervoltage_lockout_sync_q <= {supply_undervoltage_lockout_sync_q[0], supply_undervoltage_lockout_pin};
            supply_undervoltage_lockout_prev_q <= supply_undervoltage_lockout_sync_q[1];
            load_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [15:0] fb_scale_q;
    logic [15:0] floor_q;
    logic [15:0] fsw_q;
    logic [15:0] req_prev_q;

    wire wr = cmd.valid & cmd.write;
    wire rd = cmd.valid & ~cmd.write;
    wire hit_fb = cmd.code == VSF_CMD_FB_SCALE;
    wire hit_floor = cmd.code == VSF_CMD_FLOOR;
    wire hit_fsw = cmd.code == VSF_CMD_FSW;
    wire hit_any = hit_fb | hit_floor | hit_fsw;
    wire vsf_fix_t wr_fix = vsf_lin_decode(cmd.data);
    // scale must be positive and no more than unity
    wire fb_ok = (wr_fix > VSF_FIX_ZERO) && (wr_fix <= VSF_FIX_ONE);
    // floor shares the ceiling's valid window
    wire floor_ok = (cmd.data >= LIMIT_MIN) && (cmd.data <= LIMIT_MAX);
    wire wr_fb = wr & hit_fb & fb_ok;
    wire wr_floor = wr & hit_floor & floor_ok;
    wire wr_fsw = wr & hit_fsw;
    wire wr_bad = wr & ((hit_fb & ~fb_ok) | (hit_floor & ~floor_ok));
    wire [15:0] rd_word = hit_fb ? fb_scale_q : (hit_floor ? floor_q : fsw_q);

    // exponent chosen so the frequency fits a positive mantissa
    wire fsw_big = nvm_switching_khz > {1'b0, VSF_MAN_POS_MAX[9:0]};
    wire [15:0] fsw_nvm_word = fsw_big ? {VSF_SWITCHING_RATE_EXPONENT_DOUBLE, 1'b0, nvm_switching_khz[10:1]} :
        {VSF_SWITCHING_RATE_EXPONENT_UNITY, nvm_switching_khz};

    // ------------------------------------------------------------
    // Stored words
    // ------------------------------------------------------------
    // NVM load wins; a command in the load cycle is answered but dropped
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fb_scale_q <= VSF_FB_SCALE_RST;
            floor_q <= VSF_WORD_RST;
            fsw_q <= VSF_WORD_RST;
        end else if (load_q) begin
            fb_scale_q <= {VSF_FB_EXP_RST, nvm_feedback_scale[VSF_MAN_MSB:0]};
            floor_q <= nvm_output_floor_limit;
            fsw_q <= fsw_nvm_word;
        end else begin
            if (wr_fb)
                fb_scale_q <= cmd.data;
            if (wr_floor)
                floor_q <= cmd.data;
            if (wr_fsw)
                fsw_q <= cmd.data;
        end
    end

    // ------------------------------------------------------------
    // Hardware copies: blocked while converting
    // ------------------------------------------------------------
    logic [15:0] hw_fsw_q;
    // Copies track stored words while idle, so no stale value survives a stop
    wire hw_take = load_q | ~conv_on | restore_pulse | supply_undervoltage_lockout_release;
    // live copy only when conversion is off or after a reload
    wire [15:0] fb_next = (wr_fb & ~conv_on) ? cmd.data : fb_scale_q;
    wire [15:0] fsw_next = (wr_fsw & ~conv_on) ? cmd.data : fsw_q;
    wire [15:0] fb_src = load_q ? {VSF_FB_EXP_RST, nvm_feedback_scale[VSF_MAN_MSB:0]} : fb_next;
    wire [15:0] fsw_src = load_q ? fsw_nvm_word : fsw_next;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hw_feedback_scale_q <= VSF_FB_SCALE_RST;
            hw_fsw_q <= VSF_WORD_RST;
        end else if (hw_take) begin
            // raw stored scale drives reference scaling
            hw_feedback_scale_q <= fb_src;
            hw_fsw_q <= fsw_src;
        end
    end

    // ------------------------------------------------------------
    // Divider and band selection
    // ------------------------------------------------------------
    // decode before comparing
    wire vsf_fix_t hw_fb_fix = vsf_lin_decode(hw_feedback_scale_q);
    wire vsf_fix_t hw_fsw_fix = vsf_lin_decode(hw_fsw_q);
    wire vsf_div_t div_d = (hw_fb_fix <= VSF_FIX_EIGHTH) ? VSF_DIV_EIGHTH :
        (hw_fb_fix <= VSF_FIX_QUARTER) ? VSF_DIV_QUARTER :
        (hw_fb_fix <= VSF_FIX_HALF) ? VSF_DIV_HALF : VSF_DIV_ONE;
    // Integer kHz; negative or huge values saturate
    wire vsf_fix_t khz_whole = hw_fsw_fix >>> VSF_FRAC;
    wire [10:0] khz_sat = (khz_whole < 0) ? 11'd0 : ((khz_whole > 48'sd2047) ? 11'h7FF : khz_whole[10:0]);
    logic [VSF_NBAND-2:0] above;
    logic [3:0] band_idx;

    genvar gi;
    generate
        for (gi = 0; gi < VSF_NBAND - 1; gi++) begin : g_band
            // boundary value itself stays in the lower band
            assign above[gi] = khz_sat > VSF_BAND_LOW[gi];
        end
    endgenerate

    always_comb begin
        band_idx = 4'h0;
        for (int i = 0; i < VSF_NBAND - 1; i++) begin
            if (above[i])
                band_idx = 4'(i + 1);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            divider_sel_q <= VSF_DIV_EIGHTH;
            effective_khz_q <= VSF_BAND_KHZ[0];
        end else begin
            divider_sel_q <= div_d;
            effective_khz_q <= VSF_BAND_KHZ[band_idx];
        end
    end

    // ------------------------------------------------------------
    // Floor clamp, warning and slew
    // ------------------------------------------------------------
    wire [15:0] floor_now = wr_floor ? cmd.data : floor_q;
    wire [15:0] clamped = (request_target < floor_now) ? floor_now : request_target;
    // change lands below floor; new limit does the same
    wire warn_evt = conv_on & ~load_q & (request_target < floor_now) & ((request_target != req_prev_q) | wr_floor);
    wire [16:0] up_room = {1'b0, clamped} - {1'b0, vout_target_q};
    wire [16:0] dn_room = {1'b0, vout_target_q} - {1'b0, clamped};
    wire [15:0] step = output_slew_setting;
    // Zero slew would stall the output, so one code per cycle is the least
    wire [15:0] step_eff = (step == 16'h0000) ? 16'h0001 : step;
    wire [15:0] slew_next = (vout_target_q < clamped) ?
        ((up_room[15:0] > step_eff) ? vout_target_q + step_eff : clamped) :
        ((dn_room[15:0] > step_eff) ? vout_target_q - step_eff : clamped);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            req_prev_q <= VSF_WORD_RST;
            vout_target_q <= VSF_WORD_RST;
        end else begin
            req_prev_q <= request_target;
            // slew at programmed rate while converting
            vout_target_q <= conv_on ? slew_next : clamped;
        end
    end

    // ------------------------------------------------------------
    // Status and alert; a new event beats a clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= '0;
            alert_q <= 1'b0;
        end else begin
            status_q.limit_warn <= warn_evt | (status_q.limit_warn & ~clear_status);
            status_q.vout <= warn_evt | (status_q.vout & ~clear_status);
            status_q.catch_all <= warn_evt | wr_bad | (status_q.catch_all & ~clear_status);
            status_q.invalid_data <= wr_bad | (status_q.invalid_data & ~clear_status);
            alert_q <= warn_evt | wr_bad | (alert_q & ~clear_status);
        end
    end

    // ------------------------------------------------------------
    // Response
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_valid_q <= 1'b0;
            rsp_ack_q <= 1'b0;
            rsp_data_q <= VSF_WORD_RST;
        end else begin
            rsp_valid_q <= cmd.valid;
            rsp_ack_q <= cmd.valid & hit_any & ~wr_bad;
            rsp_data_q <= (rd & hit_any) ? rd_word : VSF_WORD_RST;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Checks sample on the same edge as the logic they guard
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_bad_write;
        wr & hit_floor & ~floor_ok;
    endsequence
    sequence s_flagged;
        status_q.invalid_data & status_q.catch_all & alert_q;
    endsequence

    AST_FB_READBACK: assert property (wr_fb & ~load_q |=> fb_scale_q == $past(cmd.data))
        else $error("scale not stored as written");
    AST_HW_BLOCKED: assert property (conv_on & ~restore_pulse & ~supply_undervoltage_lockout_release & ~load_q
        |=> $stable(hw_feedback_scale_q))
        else $error("hardware scale changed while converting");
    AST_HW_FREE: assert property (~conv_on & wr_fsw & ~load_q |=> hw_fsw_q == $past(cmd.data))
        else $error("frequency not applied while off");
    AST_DIV_EIGHTH: assert property (hw_fb_fix <= VSF_FIX_EIGHTH |=> divider_sel_q == VSF_DIV_EIGHTH)
        else $error("divider not eighth");
    AST_DIV_ONE: assert property (hw_fb_fix > VSF_FIX_HALF |=> divider_sel_q == VSF_DIV_ONE)
        else $error("divider not unity");
    AST_BAD_FLOOR: assert property (s_bad_write |=> s_flagged ##0 $stable(floor_q))
        else $error("invalid floor not flagged or stored");
    AST_FLOOR_CLAMP: assert property (~conv_on |=> vout_target_q >= $past(floor_now))
        else $error("target below floor");
    AST_WARN_BITS: assert property (warn_evt |=> status_q.limit_warn & status_q.vout
        & status_q.catch_all & alert_q)
        else $error("limit warning bits missing");
    AST_BAND_LOW: assert property (khz_sat <= VSF_BAND_LOW[0] |=> effective_khz_q == VSF_BAND_KHZ[0])
        else $error("gap not assigned lower band");
    AST_BAND_TOP: assert property (khz_sat > VSF_BAND_LOW[VSF_NBAND-2]
        |=> effective_khz_q == VSF_BAND_KHZ[VSF_NBAND-1])
        else $error("top band wrong");
endmodule // vsf_bank

// ### rtl/vsf_pkg.sv
/*
 Shared constants, types and the linear-format decoder for the scale, floor and frequency command bank.
 Assumes a single clock domain and a command port that delivers whole 16-bit words.
*/
package vsf_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] VSF_CMD_FB_SCALE = 8'h29;
    localparam logic [7:0] VSF_CMD_FLOOR = 8'h2B;
    localparam logic [7:0] VSF_CMD_FSW = 8'h33;
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int VSF_EXP_MSB = 15;
    localparam int VSF_EXP_LSB = 11;
    localparam int VSF_MAN_MSB = 10;
    localparam logic [4:0] VSF_FB_EXP_RST = 5'h19;
    localparam logic [15:0] VSF_FB_SCALE_RST = {VSF_FB_EXP_RST, 11'h000};
    localparam logic [15:0] VSF_WORD_RST = 16'h0000;
    localparam logic [4:0] VSF_SWITCHING_RATE_EXPONENT_UNITY = 5'h00;
    localparam logic [4:0] VSF_SWITCHING_RATE_EXPONENT_DOUBLE = 5'h01;
    localparam logic [10:0] VSF_MAN_POS_MAX = 11'h3FF;
    // ------------------------------------------------------------
    // Fixed point: 16 fractional bits
    // ------------------------------------------------------------
    localparam int VSF_FRAC = 16;
    typedef logic signed [47:0] vsf_fix_t;
    localparam vsf_fix_t VSF_FIX_EIGHTH = 48'sh0000_0000_2000;
    localparam vsf_fix_t VSF_FIX_QUARTER = 48'sh0000_0000_4000;
    localparam vsf_fix_t VSF_FIX_HALF = 48'sh0000_0000_8000;
    localparam vsf_fix_t VSF_FIX_ONE = 48'sh0000_0001_0000;
    localparam vsf_fix_t VSF_FIX_ZERO = 48'sh0000_0000_0000;
    // ------------------------------------------------------------
    // Frequency bands, kHz
    // ------------------------------------------------------------
    localparam int VSF_NBAND = 12;
    localparam logic [10:0] VSF_BAND_LOW [VSF_NBAND-1] = '{11'd250, 11'd300, 11'd350, 11'd410, 11'd500,
        11'd600, 11'd700, 11'd820, 11'd1000, 11'd1200, 11'd1400};
    localparam logic [10:0] VSF_BAND_KHZ [VSF_NBAND] = '{11'd225, 11'd275, 11'd325, 11'd375, 11'd450,
        11'd550, 11'd650, 11'd750, 11'd900, 11'd1100, 11'd1300, 11'd1500};
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {VSF_DIV_EIGHTH, VSF_DIV_QUARTER, VSF_DIV_HALF, VSF_DIV_ONE} vsf_div_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } vsf_cmd_t;
    typedef struct packed {
        logic catch_all;
        logic vout;
        logic limit_warn;
        logic invalid_data;
    } vsf_status_t;

    // Mantissa times two to the exponent, both two's complement
    function automatic vsf_fix_t vsf_lin_decode(input logic [15:0] w);
        vsf_fix_t m;
        logic signed [4:0] e;
        m = vsf_fix_t'($signed(w[VSF_MAN_MSB:0])) <<< VSF_FRAC;
        e = $signed(w[VSF_EXP_MSB:VSF_EXP_LSB]);
        vsf_lin_decode = (e < 0) ? (m >>> (-e)) : (m <<< e);
    endfunction
endpackage

// ### dv/vsf_host.sv
/*
 Bus host model: issues whole-word reads and writes on the command port.
 Assumes the bank answers with a one-cycle response pulse one cycle after the request.
*/
module vsf_host
    import vsf_pkg::*;
(
    input wire logic ref_clk,
    output vsf_cmd_t cmd,
    input wire logic rsp_valid_q,
    input wire logic rsp_ack_q,
    input wire logic [15:0] rsp_data_q
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd = '0;

    // single converter here, so no ceiling on programmed frequency
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
            output logic ack, output logic [15:0] rdata);
        int n;
        ack = 1'bx;
        rdata = 'x;
        @(posedge ref_clk);
        cmd <= '{valid: 1'b1, write: wr, code: code, data: wdata};
        @(posedge ref_clk);
        // whole words; idle data shows the inverse, not the last word
        cmd <= '{valid: 1'b0, write: wr, code: code, data: ~wdata};
        for (n = 0; n < 4; n++) begin
            @(negedge ref_clk);
            if (rsp_valid_q === 1'b1) begin
                ack = rsp_ack_q;
                rdata = rsp_data_q;
                break;
            end
        end
    endtask
endmodule // vsf_host

// ### dv/testbench.sv
/*
 Self-checking bench for the scale, floor and frequency command bank.
 Assumes the host model drives the command port; NVM scale and floor words are fixed, the NVM frequency changes at the restart.
*/
module testbench
    import vsf_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] NVM_FB = 16'h0055;
    localparam logic [15:0] FLOOR0 = 16'h0200;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [10:0] nvm_khz = 11'd900;
    logic clr_st = 1'b0, conv = 1'b0, supply_undervoltage_lockout = 1'b0, restore = 1'b0;
    logic [15:0] req = 16'h0300, slew = 16'h0100;
    vsf_cmd_t cmd;
    logic rsp_valid_q, rsp_ack_q, alert;
    logic [15:0] rsp_data_q, hw_fb, target;
    vsf_div_t div_sel;
    logic [10:0] eff_khz;
    vsf_status_t status;
    int n_fail = 0;
    int compares = 0;
    logic [15:0] sw [6] = '{16'hE801, 16'hE802, 16'hE803, 16'hE804, 16'hE805, 16'hC880};
    vsf_div_t sd [6] = '{VSF_DIV_EIGHTH, VSF_DIV_QUARTER, VSF_DIV_HALF, VSF_DIV_HALF, VSF_DIV_ONE, VSF_DIV_ONE};
    logic [15:0] fw [15] = '{16'h00F9, 16'h00FA, 16'h00FB, 16'h012C, 16'h012D, 16'h0199, 16'h019B, 16'h03E7,
        16'h03E8, 16'h09F5, 16'h0A58, 16'h0A59, 16'h0B38, 16'h0B52, 16'hFABC};
    logic [10:0] fk [15] = '{11'd225, 11'd225, 11'd275, 11'd275, 11'd325, 11'd375, 11'd450, 11'd900,
        11'd900, 11'd1100, 11'd1100, 11'd1300, 11'd1500, 11'd1500, 11'd325};

    always #50 ref_clk = ~ref_clk;

    vsf_host host (.ref_clk(ref_clk), .cmd(cmd), .rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q),
        .rsp_data_q(rsp_data_q));

    vsf_bank #(.LIMIT_MIN(16'h0100), .LIMIT_MAX(16'h8000)) dut (.ref_clk(ref_clk), .nrst(nrst), .cmd(cmd),
        .rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q), .rsp_data_q(rsp_data_q), .clear_status(clr_st),
        .conv_enable_pin(conv), .supply_undervoltage_lockout_pin(supply_undervoltage_lockout), .restore_pulse(restore),
        .nvm_feedback_scale(NVM_FB), .nvm_output_floor_limit(FLOOR0), .nvm_switching_khz(nvm_khz),
        .request_target(req), .output_slew_setting(slew), .hw_feedback_scale_q(hw_fb),
        .divider_sel_q(div_sel), .effective_khz_q(eff_khz), .vout_target_q(target), .status_q(status),
        .alert_q(alert));

    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic e);
        logic ack;
        logic [15:0] r;
        host.xfer(1'b1, code, d, ack, r);
        chk("ack", {15'h0000, e}, {15'h0000, ack});
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] e);
        logic ack;
        logic [15:0] r;
        host.xfer(1'b0, code, 16'h0000, ack, r);
        chk("read", e, r);
    endtask

    // Waits for the target, checking that it never dips under the floor meanwhile
    task automatic wait_target(input logic [15:0] e, input logic [15:0] fl);
        int n;
        for (n = 0; n < 64 && target !== e; n++) begin
            settle(1);
            chk("above floor", 16'h0001, {15'h0000, target >= fl});
        end
        if (target !== e) begin
            n_fail++;
            $display("BAD target wait expected %h seen %h", e, target);
            summarize();
        end
    endtask

    task automatic clr(input logic [3:0] e);
        chk("status", {12'h000, e}, {12'h000, status});
        chk("alert", 16'h0001, {15'h0000, alert});
        @(posedge ref_clk);
        clr_st <= 1'b1;
        @(posedge ref_clk);
        clr_st <= 1'b0;
        settle(1);
        chk("cleared", 16'h0000, {11'h000, alert, status});
    endtask

    task automatic t_reset();
        chk("fb hw", {5'h19, NVM_FB[10:0]}, hw_fb);
        rd(VSF_CMD_FB_SCALE, {5'h19, NVM_FB[10:0]});
        rd(VSF_CMD_FSW, 16'h0384);
        chk("khz", 16'd900, {5'h00, eff_khz});
        rd(VSF_CMD_FLOOR, FLOOR0);
        rd(8'h30, 16'h0000);
        wr(8'h30, 16'h1234, 1'b0);
    endtask

    task automatic t_scale();
        foreach (sw[i]) begin
            wr(VSF_CMD_FB_SCALE, sw[i], 1'b1);
            settle(2);
            chk("fb hw", sw[i], hw_fb);
            chk("divider", {14'h0000, sd[i]}, {14'h0000, div_sel});
            rd(VSF_CMD_FB_SCALE, sw[i]);
        end
    endtask

    task automatic t_invalid();
        wr(VSF_CMD_FB_SCALE, 16'h0000, 1'b0);
        wr(VSF_CMD_FB_SCALE, 16'hE80C, 1'b0);
        rd(VSF_CMD_FB_SCALE, 16'hC880);
        settle(1);
        clr(4'h9);
        wr(VSF_CMD_FLOOR, 16'h9000, 1'b0);
        wr(VSF_CMD_FLOOR, 16'h00FF, 1'b0);
        rd(VSF_CMD_FLOOR, FLOOR0);
        settle(1);
        clr(4'h9);
    endtask

    task automatic t_freq();
        foreach (fw[i]) begin
            wr(VSF_CMD_FSW, fw[i], 1'b1);
            settle(2);
            chk("khz", {5'h00, fk[i]}, {5'h00, eff_khz});
            rd(VSF_CMD_FSW, fw[i]);
        end
    endtask

    task automatic t_floor_idle();
        @(posedge ref_clk);
        req <= 16'h0100;
        settle(2);
        chk("target", FLOOR0, target);
        chk("no warning", 16'h0000, {12'h000, status});
        @(posedge ref_clk);
        req <= 16'h0300;
        settle(2);
        chk("target", 16'h0300, target);
    endtask

    task automatic t_block();
        @(posedge ref_clk);
        conv <= 1'b1;
        settle(4);
        wr(VSF_CMD_FB_SCALE, 16'hE801, 1'b1);
        wr(VSF_CMD_FSW, 16'h012C, 1'b1);
        settle(2);
        chk("fb hw", 16'hC880, hw_fb);
        chk("khz", 16'd325, {5'h00, eff_khz});
        rd(VSF_CMD_FB_SCALE, 16'hE801);
        @(posedge ref_clk);
        restore <= 1'b1;
        @(posedge ref_clk);
        restore <= 1'b0;
        settle(2);
        chk("fb hw", 16'hE801, hw_fb);
        chk("khz", 16'd275, {5'h00, eff_khz});
        wr(VSF_CMD_FSW, 16'h01F4, 1'b1);
        settle(2);
        chk("khz", 16'd275, {5'h00, eff_khz});
        @(posedge ref_clk);
        supply_undervoltage_lockout <= 1'b1;
        settle(4);
        @(posedge ref_clk);
        supply_undervoltage_lockout <= 1'b0;
        settle(5);
        chk("khz", 16'd450, {5'h00, eff_khz});
    endtask

    task automatic t_warn();
        settle(4);
        @(posedge ref_clk);
        req <= 16'h0080;
        wait_target(FLOOR0, FLOOR0);
        clr(4'hE);
        @(posedge ref_clk);
        req <= 16'h0300;
        wait_target(16'h0300, FLOOR0);
        wr(VSF_CMD_FLOOR, 16'h0400, 1'b1);
        wait_target(16'h0400, 16'h0400);
        clr(4'hE);
    endtask

    // Second reset with a high stored frequency takes the doubled-exponent path
    task automatic t_restart();
        @(posedge ref_clk);
        nrst <= 1'b0;
        nvm_khz <= 11'd1500;
        settle(1);
        chk("fb hw", {5'h19, 11'h000}, hw_fb);
        chk("khz", 16'd225, {5'h00, eff_khz});
        chk("target", 16'h0000, target);
        @(posedge ref_clk);
        nrst <= 1'b1;
        settle(4);
        rd(VSF_CMD_FSW, 16'h0AEE);
        chk("khz", 16'd1500, {5'h00, eff_khz});
        chk("target", 16'h0300, target);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        settle(4);
        t_reset();
        t_scale();
        t_invalid();
        t_freq();
        t_floor_idle();
        t_block();
        t_warn();
        t_restart();
        summarize();
    end
endmodule // testbench
